// ==== rtl/cpu_init_pkg.sv ====
// Constants and types for reset sequencing and lock-prefix checking
package cpu_init_pkg;
  // Timing, in double-rate clock cycles
  localparam int unsigned START_DELAY_CYCLES = 400;
  localparam int unsigned SELFTEST_EXTRA_CYCLES = (1 << 20) + 60;
  localparam int unsigned CNT_W = 22;
  // Reset values
  localparam logic [23:0] FIRST_FETCH_ADDR = 24'hfffff0;
  localparam logic [31:0] IP_RESET = 32'h0000fff0;
  localparam logic [31:0] FLAGS_RESET = 32'h00000002;
  localparam logic [31:0] CR0_RESET = 32'h00000010;
  localparam logic [31:0] DR7_RESET = 32'h00000400;
  localparam logic [15:0] CODE_SEL_RESET = 16'hf000;
  localparam logic [31:0] CODE_BASE_RESET = 32'hffff0000;
  localparam logic [15:0] SEG_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] IDT_LIMIT_RESET = 16'h03ff;
  localparam logic [7:0] COMPONENT_ID = 8'h04;
  localparam logic [3:0] UPPER_ADDR_HIGH = 4'hf;
  localparam logic [3:0] UPPER_ADDR_LOW = 4'h0;
  localparam int unsigned NUM_SEG = 6;
  localparam int unsigned CODE_SEG = 1;
  // Register map (word offsets in bytes)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_ACC = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [7:0] REG_CODE_SEG = 8'h18;
  localparam logic [7:0] REG_IDT = 8'h1c;
  localparam logic [7:0] REG_DECODE = 8'h20;
  // Control bits
  localparam int unsigned CTRL_SELFTEST = 0;
  localparam int unsigned CTRL_ST_FAIL = 1;
  // Interrupt event bits
  localparam int unsigned EV_RUN = 0;
  localparam int unsigned EV_UD = 1;
  localparam int unsigned EV_FAR = 2;
  localparam int unsigned EV_W = 3;
  // Decode port fields
  localparam int unsigned DEC_OP_LO = 0;
  localparam int unsigned DEC_OP_HI = 7;
  localparam int unsigned DEC_LOCK = 8;
  localparam int unsigned DEC_MEM = 9;
  localparam int unsigned DEC_EXT = 10;
  localparam int unsigned DEC_OSZ = 11;
  localparam int unsigned DEC_CNT_LO = 12;
  localparam int unsigned DEC_CNT_HI = 13;
  localparam int unsigned DEC_IMM = 14;
  localparam logic [1:0] MAX_OPERANDS = 2'd3;
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} opsize_t;
  typedef enum {ST_RESET, ST_WAIT, ST_RUN} seq_state_t;
endpackage : cpu_init_pkg

// ==== rtl/seg_if.sv ====
// Segment register file access bundle
`timescale 1ns/1ps
interface seg_if;
  logic init;
  logic load;
  logic [2:0] idx;
  logic [15:0] sel;
  logic [31:0] base;
  logic [2:0] rd_idx;
  logic [15:0] rd_sel;
  logic [31:0] rd_base;
  logic [15:0] rd_limit;
  modport ctrl (output init, load, idx, sel, base, rd_idx,
                input rd_sel, rd_base, rd_limit);
  modport mem (input init, load, idx, sel, base, rd_idx,
               output rd_sel, rd_base, rd_limit);
endinterface : seg_if

// ==== rtl/seg_regs.sv ====
// Six segment registers with hidden base and limit, registered read
`timescale 1ns/1ps
module seg_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n,
  // Access
  seg_if.mem sif
);
  logic [15:0] sel_q [cpu_init_pkg::NUM_SEG];
  logic [31:0] base_q [cpu_init_pkg::NUM_SEG];
  logic [15:0] limit_q [cpu_init_pkg::NUM_SEG];

  for (genvar g = 0; g < cpu_init_pkg::NUM_SEG; g++) begin : g_seg
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        sel_q[g] <= '0;
        base_q[g] <= '0;
        limit_q[g] <= '0;
      end else if (sif.init) begin
        // Code segment high, others zero; all limits full
        sel_q[g] <= (g == cpu_init_pkg::CODE_SEG) ?
                    cpu_init_pkg::CODE_SEL_RESET : '0;
        base_q[g] <= (g == cpu_init_pkg::CODE_SEG) ?
                     cpu_init_pkg::CODE_BASE_RESET : '0;
        limit_q[g] <= cpu_init_pkg::SEG_LIMIT_RESET;
      end else if (sif.load && sif.idx == 3'(g)) begin
        sel_q[g] <= sif.sel;
        base_q[g] <= sif.base;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sif.rd_sel <= '0;
      sif.rd_base <= '0;
      sif.rd_limit <= '0;
    end else if (sif.rd_idx < 3'(cpu_init_pkg::NUM_SEG)) begin
      sif.rd_sel <= sel_q[sif.rd_idx];
      sif.rd_base <= base_q[sif.rd_idx];
      sif.rd_limit <= limit_q[sif.rd_idx];
    end else begin
      sif.rd_sel <= '0;
      sif.rd_base <= '0;
      sif.rd_limit <= '0;
    end
  end
endmodule : seg_regs

// ==== rtl/cpu_reset_init.sv ====
// Reset/initialization sequencer and lock-prefix decode check
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module cpu_reset_init #(
  parameter int unsigned START_DELAY = cpu_init_pkg::START_DELAY_CYCLES,
  parameter int unsigned SELFTEST_EXTRA =
    cpu_init_pkg::SELFTEST_EXTRA_CYCLES,
  parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Decode and bus status
  input wire logic dec_valid_i,
  input wire logic [15:0] dec_info_i,
  input wire logic far_xfer_i,
  input wire logic rmw_done_i,
  output logic lock_o,
  output logic ud_fault_o,
  output logic [1:0] operand_count_o,
  output logic [1:0] operand_size_o,
  output logic imm_prefetch_o,
  // Core state
  output logic run_o,
  output logic [23:0] fetch_addr_o,
  output logic [3:0] upper_address_lines_o,
  output logic cache_enable_o,
  output logic paging_enable_o,
  output logic real_mode_o,
  output logic [31:0] flags_o,
  output logic [31:0] cr0_o,
  output logic [31:0] dr7_o,
  output logic irq_o
);
  logic rst_meta, rst_n;
  cpu_init_pkg::seq_state_t state;
  logic [cpu_init_pkg::CNT_W-1:0] count;
  logic [cpu_init_pkg::CNT_W-1:0] target;
  logic [31:0] ctrl, accumulator_reg, data_reg;
  logic [31:0] idt_base;
  logic [15:0] idt_limit;
  logic far_seen, locked_op, ud_ev;
  logic [3:0] irq_stat, irq_mask, next_stat, events;
  seg_if sif();

  // Reset synchroniser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Lockable read-modify-write opcodes (first opcode byte class)
  function automatic logic lockable(input logic [7:0] op, input logic ext);
    logic r;
    r = 1'b0;
    if (ext) begin
      // Bit test-and-modify, exchange-add, compare-exchange
      r = (op == 8'hab) || (op == 8'hb3) || (op == 8'hbb) ||
          (op == 8'hba) || (op == 8'hc0) || (op == 8'hc1) ||
          (op == 8'hb0) || (op == 8'hb1);
    end else begin
      // ADD OR ADC SBB AND SUB XOR forms to memory
      r = (op[7:6] == 2'b00 && op[2:1] == 2'b00 && op[5:3] != 3'b111) ||
          (op >= 8'h80 && op <= 8'h83) ||
          (op == 8'h86) || (op == 8'h87) ||
          (op == 8'hf6) || (op == 8'hf7) ||
          (op == 8'hfe) || (op == 8'hff);
    end
    return r;
  endfunction : lockable

  // Delay target latched at release from self-test request
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      target <= '0;
    end else if (state == cpu_init_pkg::ST_RESET) begin
      target <= ctrl[cpu_init_pkg::CTRL_SELFTEST] ?
        cpu_init_pkg::CNT_W'(START_DELAY + SELFTEST_EXTRA) :
        cpu_init_pkg::CNT_W'(START_DELAY);
    end
  end

  // Sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= cpu_init_pkg::ST_RESET;
      count <= '0;
    end else begin
      case (state)
        cpu_init_pkg::ST_RESET: begin
          state <= cpu_init_pkg::ST_WAIT;
          count <= '0;
        end
        cpu_init_pkg::ST_WAIT: begin
          count <= count + 1'b1;
          if (count + 1'b1 >= target)
            state <= cpu_init_pkg::ST_RUN;
        end
        cpu_init_pkg::ST_RUN: state <= cpu_init_pkg::ST_RUN;
        default: state <= cpu_init_pkg::ST_RESET;
      endcase
    end
  end

  assign run_o = (state == cpu_init_pkg::ST_RUN);

  // Architectural initial values
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      real_mode_o <= 1'b1;
      cache_enable_o <= 1'b0;
      paging_enable_o <= 1'b0;
      flags_o <= cpu_init_pkg::FLAGS_RESET;
      cr0_o <= cpu_init_pkg::CR0_RESET;
      dr7_o <= cpu_init_pkg::DR7_RESET;
      idt_base <= '0;
      idt_limit <= cpu_init_pkg::IDT_LIMIT_RESET;
    end else begin
      real_mode_o <= real_mode_o;
      cache_enable_o <= cache_enable_o;
      paging_enable_o <= paging_enable_o;
    end
  end

  // Segment file is reinitialised while held in reset state
  assign sif.init = (state == cpu_init_pkg::ST_RESET);
  assign sif.load = 1'b0;
  assign sif.idx = '0;
  assign sif.sel = '0;
  assign sif.base = '0;
  assign sif.rd_idx = 3'(cpu_init_pkg::CODE_SEG);

  seg_regs u_seg (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .sif(sif)
  );

  // Accumulator and data register; general registers left undefined
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_reg <= '0;
      data_reg <= '0;
    end else if (state == cpu_init_pkg::ST_WAIT && count + 1'b1 >= target)
    begin
      // Zero on self-test pass; all ones on failure or when no self-test ran
      accumulator_reg <= (ctrl[cpu_init_pkg::CTRL_SELFTEST] &&
                          !ctrl[cpu_init_pkg::CTRL_ST_FAIL]) ? '0 : '1;
      data_reg <= {16'h0000, cpu_init_pkg::COMPONENT_ID,
                   REVISION_ID};
    end
  end

  // Fetch address and upper address lines
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      far_seen <= 1'b0;
    end else if (run_o && far_xfer_i) begin
      far_seen <= 1'b1;
    end
  end

  assign fetch_addr_o = cpu_init_pkg::FIRST_FETCH_ADDR;
  assign upper_address_lines_o = (!run_o || far_seen) ?
    (far_seen ? cpu_init_pkg::UPPER_ADDR_LOW :
     cpu_init_pkg::UPPER_ADDR_HIGH) :
    cpu_init_pkg::UPPER_ADDR_HIGH;

  // Decode check and lock output
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      locked_op <= 1'b0;
      ud_ev <= 1'b0;
      operand_count_o <= '0;
      operand_size_o <= cpu_init_pkg::SZ_16;
      imm_prefetch_o <= 1'b0;
    end else begin
      ud_ev <= 1'b0;
      if (run_o && dec_valid_i) begin
        operand_count_o <= (dec_info_i[cpu_init_pkg::DEC_CNT_HI:
          cpu_init_pkg::DEC_CNT_LO] > cpu_init_pkg::MAX_OPERANDS) ?
          cpu_init_pkg::MAX_OPERANDS :
          dec_info_i[cpu_init_pkg::DEC_CNT_HI:cpu_init_pkg::DEC_CNT_LO];
        imm_prefetch_o <= dec_info_i[cpu_init_pkg::DEC_IMM];
        // Real mode defaults to 16 bits; override flips it
        operand_size_o <= dec_info_i[cpu_init_pkg::DEC_OP_LO] ?
          ((dec_info_i[cpu_init_pkg::DEC_OSZ] ^ real_mode_o) ?
           cpu_init_pkg::SZ_16 : cpu_init_pkg::SZ_32) :
          cpu_init_pkg::SZ_8;
        if (dec_info_i[cpu_init_pkg::DEC_LOCK]) begin
          if (lockable(dec_info_i[cpu_init_pkg::DEC_OP_HI:
                cpu_init_pkg::DEC_OP_LO], dec_info_i[cpu_init_pkg::DEC_EXT])
              && dec_info_i[cpu_init_pkg::DEC_MEM])
            locked_op <= 1'b1;
          else
            ud_ev <= 1'b1;
        end
      end else if (rmw_done_i || !run_o) begin
        locked_op <= 1'b0;
      end
    end
  end

  assign lock_o = locked_op && run_o;
  assign ud_fault_o = ud_ev;

  // Sticky events, cleared by a status read; set wins
  assign events = {1'b0, far_xfer_i && run_o && !far_seen, ud_ev,
                   state == cpu_init_pkg::ST_WAIT && count + 1'b1 >= target};
  always_comb begin
    next_stat = irq_stat;
    if (rd_i && addr_i == cpu_init_pkg::REG_IRQ_STAT)
      next_stat = '0;
    next_stat = next_stat | events;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) irq_stat <= '0;
    else irq_stat <= next_stat;
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Control survives reset, so a self-test request applies at next release
  always_ff @(posedge clk_i) begin
    if (wr_i && addr_i == cpu_init_pkg::REG_CTRL) begin
      ctrl <= wdata_i;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (wr_i && addr_i == cpu_init_pkg::REG_IRQ_MASK) begin
      irq_mask <= wdata_i[cpu_init_pkg::EV_W:0];
    end
  end

  // Register reads, data one cycle later
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        cpu_init_pkg::REG_CTRL: rdata_o <= ctrl;
        cpu_init_pkg::REG_STATUS:
          rdata_o <= {27'h0, far_seen, lock_o, real_mode_o,
                      cache_enable_o, run_o};
        cpu_init_pkg::REG_IRQ_STAT: rdata_o <= {28'h0, irq_stat};
        cpu_init_pkg::REG_IRQ_MASK: rdata_o <= {28'h0, irq_mask};
        cpu_init_pkg::REG_ACC: rdata_o <= accumulator_reg;
        cpu_init_pkg::REG_DATA: rdata_o <= data_reg;
        cpu_init_pkg::REG_CODE_SEG: rdata_o <= {sif.rd_sel, sif.rd_limit};
        cpu_init_pkg::REG_IDT: rdata_o <= idt_base | 32'(idt_limit);
        cpu_init_pkg::REG_DECODE: rdata_o <= sif.rd_base;
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // Checks
  a_no_run_early: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(run_o) |-> $past(count, 1) + 1'b1 >= target)
    else $error("execution started before delay");
  a_lock_only_run: assert property (@(posedge clk_i) disable iff (!rst_n)
    !run_o |-> !locked_op && !lock_o)
    else $error("lock asserted outside run");
  a_ud_on_reg_dest: assert property (@(posedge clk_i) disable iff (!rst_n)
    run_o && dec_valid_i && dec_info_i[cpu_init_pkg::DEC_LOCK] &&
    !dec_info_i[cpu_init_pkg::DEC_MEM] |=> ud_fault_o && !$rose(lock_o))
    else $error("register destination lock not faulted");
  a_upper_low_far: assert property (@(posedge clk_i) disable iff (!rst_n)
    far_seen |-> upper_address_lines_o == cpu_init_pkg::UPPER_ADDR_LOW)
    else $error("upper lines not low after far transfer");
  a_upper_high_init: assert property (@(posedge clk_i) disable iff (!rst_n)
    !far_seen |-> upper_address_lines_o == cpu_init_pkg::UPPER_ADDR_HIGH)
    else $error("upper lines not high after reset");
  a_cache_off_wait: assert property (@(posedge clk_i) disable iff (!rst_n)
    !run_o |-> !cache_enable_o && !paging_enable_o && real_mode_o)
    else $error("cache or paging on during init");
  a_code_seg_init: assert property (@(posedge clk_i) disable iff (!rst_n)
    state == cpu_init_pkg::ST_WAIT && count > 2 |->
    sif.rd_sel == cpu_init_pkg::CODE_SEL_RESET &&
    sif.rd_base == cpu_init_pkg::CODE_BASE_RESET)
    else $error("code segment not initialised");
  a_ud_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
    ud_fault_o |=> !ud_fault_o || $past(dec_valid_i))
    else $error("fault pulse stuck");
  a_lock_held_seq: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    lock_o && !rmw_done_i |=> lock_o)
    else $error("lock dropped before sequence end");
  a_lock_release: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    lock_o && rmw_done_i && !dec_valid_i |=> !lock_o)
    else $error("lock held after sequence end");
  a_run_delay_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    $rose(run_o) |->
    target == cpu_init_pkg::CNT_W'(START_DELAY) ||
    target == cpu_init_pkg::CNT_W'(START_DELAY + SELFTEST_EXTRA))
    else $error("start delay not a documented length");
  a_stat_sticky: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !(rd_i && addr_i == cpu_init_pkg::REG_IRQ_STAT) |=>
    (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit lost without a read");
endmodule : cpu_reset_init

// ==== bench/local_bus_model.sv ====
// Far-side bus model: ends locked sequences, reports far transfers
`timescale 1ns/1ps
module local_bus_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // From the sequencer
  input wire logic lock_i,
  // Bench controls
  input wire logic far_req_i,
  input wire logic [3:0] hold_i,
  // To the sequencer
  output logic far_xfer_o,
  output logic rmw_done_o
);
  logic [3:0] held;
  logic busy;

  // One done pulse per locked sequence, after a chosen hold
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      held <= 4'h0;
      busy <= 1'b0;
      rmw_done_o <= 1'b0;
    end else begin
      rmw_done_o <= 1'b0;
      if (!lock_i) begin
        held <= 4'h0;
        busy <= 1'b0;
      end else if (!busy) begin
        held <= held + 4'h1;
        if (held == hold_i) begin
          rmw_done_o <= 1'b1;
          busy <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      far_xfer_o <= 1'b0;
    end else begin
      far_xfer_o <= far_req_i;
    end
  end
endmodule : local_bus_model

// ==== bench/cpu_reset_init_and_lock_check_tb_top.sv ====
// Self-checking bench for the reset sequencer and lock check
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_reset_init_and_lock_check_tb_top;
  localparam int unsigned SD = 20;
  localparam int unsigned SE = 30;
  localparam logic [7:0] REV = 8'h5a;  // Arbitrary value
  // {lockable, escape, opcode}
  localparam logic [9:0] OPS [27] = '{10'h200, 10'h201, 10'h208,
    10'h209, 10'h210, 10'h211, 10'h218, 10'h219, 10'h220, 10'h221,
    10'h228, 10'h229, 10'h230, 10'h231, 10'h286, 10'h287, 10'h3ab,
    10'h3b3, 10'h3bb, 10'h3c0, 10'h3c1, 10'h3b0, 10'h3b1, 10'h088,
    10'h08a, 10'h1a3, 10'h1b6};
  logic clk_i, resetn_i, wr_i, rd_i, dec_valid_i, far_xfer_i, rmw_done_i;
  logic lock_o, ud_fault_o, imm_prefetch_o, run_o, irq_o, far_req;
  logic cache_enable_o, paging_enable_o, real_mode_o;
  logic [7:0] addr_i;
  logic [15:0] dec_info_i;
  logic [1:0] operand_count_o, operand_size_o;
  logic [23:0] fetch_addr_o;
  logic [3:0] upper_address_lines_o, hold;
  logic [31:0] wdata_i, rdata_o, flags_o, cr0_o, dr7_o;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h4a4931fd;

  cpu_reset_init #(.START_DELAY(SD), .SELFTEST_EXTRA(SE),
    .REVISION_ID(REV)) dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .dec_valid_i, .dec_info_i, .far_xfer_i, .rmw_done_i,
    .lock_o, .ud_fault_o, .operand_count_o, .operand_size_o,
    .imm_prefetch_o, .run_o, .fetch_addr_o, .upper_address_lines_o,
    .cache_enable_o, .paging_enable_o, .real_mode_o, .flags_o, .cr0_o,
    .dr7_o, .irq_o);

  local_bus_model bus (.clk_i, .resetn_i, .lock_i(lock_o),
    .far_req_i(far_req), .hold_i(hold), .far_xfer_o(far_xfer_i),
    .rmw_done_o(rmw_done_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask : rd

  // Reset, then count cycles from release to the run flag
  task automatic start(input int lo);
    int t;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(run_o, 1'b0)
    `CHK(lock_o, 1'b0)
    `CHK(cache_enable_o, 1'b0)
    `CHK(paging_enable_o, 1'b0)
    `CHK(real_mode_o, 1'b1)
    @(posedge clk_i);
    resetn_i <= 1'b1;
    t = 0;
    while (run_o !== 1'b1 && t < 5000) begin
      @(posedge clk_i);
      #1;
      t++;
    end
    `CHK(t >= lo && t <= lo + 5, 1'b1)
    `CHK(upper_address_lines_o, 4'hf)
    $display("test start done after %0d cycles", t);
  endtask : start

  task automatic decode(input logic [15:0] info, input logic ok);
    logic lk;
    logic [1:0] sz;
    int w;
    lk = info[8] & ok & info[9];
    sz = !info[0] ? 2'd0 : (info[11] ? 2'd2 : 2'd1);
    @(posedge clk_i);
    dec_info_i <= info;
    dec_valid_i <= 1'b1;
    @(posedge clk_i);
    dec_valid_i <= 1'b0;
    #1;
    `CHK(ud_fault_o, info[8] & !(ok & info[9]))
    `CHK(lock_o, lk)
    `CHK(operand_count_o, info[13:12])
    `CHK(imm_prefetch_o, info[14])
    `CHK(operand_size_o, sz)
    w = 0;
    while (lk && rmw_done_i !== 1'b1 && w < 40) begin
      `CHK(lock_o, 1'b1)
      @(posedge clk_i);
      #1;
      w++;
    end
    if (lk) begin
      @(posedge clk_i);
      #1;
      `CHK(lock_o, 1'b0)
    end
  endtask : decode

  initial begin
    int r;
    int k;
    resetn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    dec_valid_i = 1'b0;
    dec_info_i = 16'h0;
    far_req = 1'b0;
    hold = 4'h1;
    wr(8'h00, 32'h0);
    start(SD);
    `CHK(fetch_addr_o, 24'hfffff0)
    `CHK(flags_o, 32'h00000002)
    `CHK(cr0_o, 32'h00000010)
    `CHK(dr7_o, 32'h00000400)
    `CHK(irq_o, 1'b0)
    rd(8'h10, 32'hffffffff);
    rd(8'h14, {16'h0000, 8'h04, REV});
    rd(8'h18, 32'hf000ffff);
    rd(8'h20, 32'hffff0000);
    rd(8'h1c, 32'h000003ff);
    rd(8'h04, 32'h00000005);
    wr(8'h0c, 32'h7);
    wr(8'h3c, 32'h1);
    rd(8'h3c, 32'h0);
    rd(8'h0c, 32'h7);
    `CHK(irq_o, 1'b1)
    rd(8'h08, 32'h1);
    @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0)
    $display("test registers done");
    wr(8'h0c, 32'h5);
    foreach (OPS[i]) begin
      decode({5'h00, OPS[i][8], 1'b1, 1'b1, OPS[i][7:0]}, OPS[i][9]);
      decode({5'h01, OPS[i][8], 1'b0, 1'b1, OPS[i][7:0]}, OPS[i][9]);
    end
    for (k = 0; k < 60; k++) begin
      r = $random(seed);
      hold <= {1'b0, r[2:0]} + 4'd1;
      decode({1'b0, r[14:11], OPS[r[20:16] % 27][8], r[9:8],
        OPS[r[20:16] % 27][7:0]}, OPS[r[20:16] % 27][9]);
    end
    `CHK(irq_o, 1'b0)
    rd(8'h08, 32'h2);
    $display("test decode done");
    @(posedge clk_i);
    far_req <= 1'b1;
    @(posedge clk_i);
    far_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(upper_address_lines_o, 4'h0)
    `CHK(irq_o, 1'b1)
    rd(8'h04, 32'h15);
    rd(8'h08, 32'h4);
    $display("test far done");
    hold <= 4'hf;
    decode(16'h0301, 1'b1);
    start(SD);
    wr(8'h00, 32'h1);
    start(SD + SE);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h3);
    start(SD + SE);
    rd(8'h10, 32'hffffffff);
    $display("test selftest done");
    give_verdict();
  end
endmodule : cpu_reset_init_and_lock_check_tb_top
